// *** core/ea_consts.svh ***
// Timing counts, field positions and reset values of the offset generator.
// Contract
// - Direct mode uses the displacement alone as the operand offset.
// - Register indirect mode uses one base or index register as the offset.
// - Indirect jumps and calls may take any 16-bit general register as target.
// - Based mode adds displacement to the general base or stack base register.
// - Any use of the stack base register selects the stack segment unless overridden.
// - Indexed mode adds displacement to the source or destination index register.
// - Based indexed mode sums one base, one index and the displacement.
// - String operations use source and destination index registers implicitly.
// - Repeated string operations step both index pointers after every element.
// - Memory-mapped ports are reachable through every memory mode, strings included.
// - Direct port addressing takes an 8-bit immediate, ports 0 to 255.
// - Indirect port addressing takes the port number register, ports 0 to 65535.
// - Immediate operands may be sources only, never destinations.
// - Nearly every instruction supports byte or word width chosen by encoding.
// - Arithmetic, shift and compare work on memory operands in place.
// - The decoder recognizes 28 distinct move encodings.
// - Eight single-byte increment encodings each target one 16-bit register.
// - A memory increment is encoded in two, three or four bytes.
// - The data transfer group holds 14 instructions.
// - The offset is an unsigned 16-bit byte distance into the segment.
// - Offset plus shifted segment base gives a 20-bit physical address.
// - A segment override adds two clocks to the offset computation.
`ifndef EA_CONSTS_SVH
`define EA_CONSTS_SVH

// Offset computation times in processor clocks.
`define LAT_DISP        4'h6
`define LAT_BASE_OR_IDX 4'h5
`define LAT_DISP_ONE    4'h9
`define LAT_BI_FAST     4'h7
`define LAT_BI_SLOW     4'h8
`define LAT_FULL_FAST   4'hB
`define LAT_FULL_SLOW   4'hC
`define LAT_OVERRIDE    4'h2
`define LAT_SIMPLE      4'h1

// Field positions and widths.
`define SEG_SHIFT       4
`define PORT_IMM_W      8
`define MODRM_MOD_MEM   2'h3

// Reset values.
`define OFFSET_RST      16'h0000
`define ADDR_RST        20'h00000

`endif

// *** core/ea_pkg.sv ***
// Types shared by the offset generator and its self-checking bench.
package ea_pkg;

  // Addressing modes requested by the execution unit.
  typedef enum logic [3:0] {
    MODE_DIRECT        = 4'h0,
    MODE_REG_IND       = 4'h1,
    MODE_BASED         = 4'h2,
    MODE_INDEXED       = 4'h3,
    MODE_BASED_INDEXED = 4'h4,
    MODE_STRING        = 4'h5,
    MODE_PORT_DIRECT   = 4'h6,
    MODE_PORT_INDIRECT = 4'h7,
    MODE_JUMP_IND      = 4'h8
  } mode_type;

  // Segment register selection.
  typedef enum logic [1:0] {
    SEG_EXTRA = 2'h0,
    SEG_CODE  = 2'h1,
    SEG_STACK = 2'h2,
    SEG_DATA  = 2'h3
  } seg_type;

  // Controller states.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CALC = 1'b1
  } state_type;

endpackage

// *** core/effective_address_gen.sv ***
// Operand offset, segment, physical address and port number generator.
`timescale 1ns/1ps
`default_nettype none
`include "ea_consts.svh"
module effective_address_gen
  import ea_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  // Request from the execution unit.
  input  wire logic        start_in,
  input  wire mode_type    mode_in,
  input  wire logic        base_sel_in,
  input  wire logic        index_sel_in,
  input  wire logic        use_index_in,
  input  wire logic        disp_en_in,
  input  wire logic [15:0] disp_in,
  input  wire logic        override_in,
  input  wire seg_type     override_seg_in,
  input  wire logic        dest_imm_in,
  input  wire logic [7:0]  port_imm_in,
  // Register file contents.
  input  wire logic [15:0] general_base_reg_in,
  input  wire logic [15:0] stack_base_pointer_in,
  input  wire logic [15:0] source_index_reg_in,
  input  wire logic [15:0] destination_index_reg_in,
  input  wire logic [15:0] port_number_reg_in,
  input  wire logic [15:0] jump_reg_in,
  // Segment registers.
  input  wire logic [15:0] seg_extra_in,
  input  wire logic [15:0] seg_code_in,
  input  wire logic [15:0] seg_stack_in,
  input  wire logic [15:0] seg_data_in,
  // String element stepping.
  input  wire logic        step_in,
  input  wire logic        dir_down_in,
  input  wire logic        word_in,
  // Instruction bytes for classification.
  input  wire logic [7:0]  opcode_in,
  input  wire logic [7:0]  modrm_in,
  // Result.
  output logic             busy_out,
  output logic             done_out,
  output logic             refused_out,
  output logic [15:0]      offset_out,
  output seg_type          seg_out,
  output logic [19:0]      phys_addr_out,
  output logic             io_cycle_out,
  output logic [15:0]      port_out,
  // String pointers.
  output logic [15:0]      src_ptr_out,
  output logic [15:0]      dst_ptr_out,
  output logic [19:0]      dst_phys_out,
  // Classification.
  output logic             is_move_out,
  output logic             is_transfer_out,
  output logic             inc_reg_out,
  output logic             inc_mem_out,
  output logic [2:0]       instr_len_out,
  output logic             word_op_out,
  output logic             mem_in_place_out
);

  // Wrapping three-term offset sum; carry out of bit 15 is dropped.
  function automatic logic [15:0] ea_sum(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [15:0] c);
    ea_sum = a + b + c;
  endfunction

  // Shifted segment base plus offset, truncated to the address width.
  function automatic logic [19:0] phys_calc(input logic [15:0] seg,
                                            input logic [15:0] off);
    phys_calc = {seg, 4'h0} + {4'h0, off};
  endfunction

  // Pointer step by one byte or one word, up or down.
  function automatic logic [15:0] ptr_step(input logic [15:0] p,
                                           input logic        down,
                                           input logic        word);
    logic [15:0] d;
    d = word ? 16'h0002 : 16'h0001;
    ptr_step = down ? p - d : p + d;
  endfunction

  state_type   state_r;
  logic [3:0]  cnt_r;
  logic        busy_r;
  logic        done_r;
  logic        refused_r;
  logic        take;
  logic [15:0] base_val;
  logic [15:0] idx_val;
  logic [15:0] off_nxt;
  logic [3:0]  lat_nxt;
  seg_type     seg_nxt;
  seg_type     seg_r;
  seg_type     pend_seg_r;
  logic        io_nxt;
  logic        mem_mode;
  logic [15:0] pend_off_r;
  logic        pend_io_r;
  logic [15:0] offset_r;
  logic [19:0] phys_r;
  logic [15:0] seg_base;
  logic        io_r;
  logic [15:0] port_r;
  logic [15:0] src_ptr_r;
  logic [15:0] dst_ptr_r;
  logic [19:0] dst_phys_r;
  logic        c_move;
  logic        c_xfer;
  logic        c_inc_reg;
  logic        c_inc_mem;
  logic [2:0]  c_len;
  logic        c_word;
  logic        c_in_place;
  logic        is_move_r;
  logic        is_xfer_r;
  logic        inc_reg_r;
  logic        inc_mem_r;
  logic [2:0]  len_r;
  logic        word_r;
  logic        in_place_r;

  // A request is taken only when idle and not naming an immediate destination.
  assign take = start_in && (state_r == ST_IDLE) && !dest_imm_in;

  // Operand component selection.
  assign base_val = base_sel_in ? stack_base_pointer_in : general_base_reg_in;
  assign idx_val  = index_sel_in ? destination_index_reg_in : source_index_reg_in;

  // Offset, segment and computation time for the requested mode.
  always_comb begin
    off_nxt  = `OFFSET_RST;
    lat_nxt  = `LAT_SIMPLE;
    seg_nxt  = SEG_DATA;
    io_nxt   = 1'b0;
    mem_mode = 1'b1;
    unique case (mode_in)
      MODE_DIRECT: begin
        off_nxt = disp_in;
        lat_nxt = `LAT_DISP;
      end
      MODE_REG_IND: begin
        off_nxt = use_index_in ? idx_val : base_val;
        lat_nxt = `LAT_BASE_OR_IDX;
        if (!use_index_in && base_sel_in) begin
          seg_nxt = SEG_STACK;
        end
      end
      MODE_BASED: begin
        off_nxt = ea_sum(disp_in, base_val, 16'h0000);
        lat_nxt = `LAT_DISP_ONE;
        if (base_sel_in) begin
          seg_nxt = SEG_STACK;
        end
      end
      MODE_INDEXED: begin
        off_nxt = ea_sum(disp_in, 16'h0000, idx_val);
        lat_nxt = `LAT_DISP_ONE;
      end
      MODE_BASED_INDEXED: begin
        off_nxt = ea_sum(disp_en_in ? disp_in : 16'h0000, base_val, idx_val);
        if (base_sel_in == index_sel_in) begin
          lat_nxt = disp_en_in ? `LAT_FULL_FAST : `LAT_BI_FAST;
        end else begin
          lat_nxt = disp_en_in ? `LAT_FULL_SLOW : `LAT_BI_SLOW;
        end
        if (base_sel_in) begin
          seg_nxt = SEG_STACK;
        end
      end
      MODE_STRING: begin
        off_nxt = source_index_reg_in;
      end
      MODE_PORT_DIRECT: begin
        off_nxt  = {{(16 - `PORT_IMM_W){1'b0}}, port_imm_in};
        io_nxt   = 1'b1;
        mem_mode = 1'b0;
      end
      MODE_PORT_INDIRECT: begin
        off_nxt  = port_number_reg_in;
        io_nxt   = 1'b1;
        mem_mode = 1'b0;
      end
      MODE_JUMP_IND: begin
        off_nxt  = jump_reg_in;
        seg_nxt  = SEG_CODE;
        mem_mode = 1'b0;
      end
      default: begin
        mem_mode = 1'b0;
      end
    endcase
    // Every memory mode, strings included, honours an override at a cost.
    if (override_in && mem_mode) begin
      seg_nxt = override_seg_in;
      lat_nxt = lat_nxt + `LAT_OVERRIDE;
    end
  end

  // Sequencer: counts the computation time of the taken request.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      busy_r  <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= ST_CALC;
            cnt_r   <= lat_nxt;
            busy_r  <= 1'b1;
          end
        end
        ST_CALC: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Results are held from the taking edge and presented on completion.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_off_r <= `OFFSET_RST;
      pend_seg_r <= SEG_DATA;
      pend_io_r  <= 1'b0;
    end else if (take) begin
      pend_off_r <= off_nxt;
      pend_seg_r <= seg_nxt;
      pend_io_r  <= io_nxt;
    end
  end

  // Segment base used for the physical address.
  always_comb begin
    unique case (pend_seg_r)
      SEG_EXTRA: seg_base = seg_extra_in;
      SEG_CODE:  seg_base = seg_code_in;
      SEG_STACK: seg_base = seg_stack_in;
      SEG_DATA:  seg_base = seg_data_in;
    endcase
  end

  // Completion outputs, updated on the last computation edge.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_r   <= 1'b0;
      offset_r <= `OFFSET_RST;
      seg_r    <= SEG_DATA;
      phys_r   <= `ADDR_RST;
      io_r     <= 1'b0;
      port_r   <= `OFFSET_RST;
    end else begin
      done_r <= (state_r == ST_CALC) && (cnt_r == 4'h1);
      if ((state_r == ST_CALC) && (cnt_r == 4'h1)) begin
        io_r <= pend_io_r;
        if (pend_io_r) begin
          port_r <= pend_off_r;
        end else begin
          offset_r <= pend_off_r;
          seg_r    <= pend_seg_r;
          phys_r   <= phys_calc(seg_base, pend_off_r);
        end
      end
    end
  end

  // Immediate destinations are refused with a one-cycle pulse.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= start_in && (state_r == ST_IDLE) && dest_imm_in;
    end
  end

  // Implicit string pointers: loaded on a string request, stepped per element.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_ptr_r  <= `OFFSET_RST;
      dst_ptr_r  <= `OFFSET_RST;
      dst_phys_r <= `ADDR_RST;
    end else begin
      if (take && mode_in == MODE_STRING) begin
        src_ptr_r <= source_index_reg_in;
        dst_ptr_r <= destination_index_reg_in;
      end else if (step_in) begin
        src_ptr_r <= ptr_step(src_ptr_r, dir_down_in, word_in);
        dst_ptr_r <= ptr_step(dst_ptr_r, dir_down_in, word_in);
      end
      dst_phys_r <= phys_calc(seg_extra_in, dst_ptr_r);
    end
  end

  // Instruction classification.
  opcode_classifier u_class (
    .opcode_in        (opcode_in),
    .modrm_in         (modrm_in),
    .is_move_out      (c_move),
    .is_transfer_out  (c_xfer),
    .inc_reg_out      (c_inc_reg),
    .inc_mem_out      (c_inc_mem),
    .instr_len_out    (c_len),
    .word_op_out      (c_word),
    .mem_in_place_out (c_in_place)
  );

  // Classification is registered one cycle after the bytes are presented.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      is_move_r  <= 1'b0;
      is_xfer_r  <= 1'b0;
      inc_reg_r  <= 1'b0;
      inc_mem_r  <= 1'b0;
      len_r      <= 3'h0;
      word_r     <= 1'b0;
      in_place_r <= 1'b0;
    end else begin
      is_move_r  <= c_move;
      is_xfer_r  <= c_xfer;
      inc_reg_r  <= c_inc_reg;
      inc_mem_r  <= c_inc_mem;
      len_r      <= c_len;
      word_r     <= c_word;
      in_place_r <= c_in_place;
    end
  end

  // Outputs straight from flip-flops.
  assign busy_out         = busy_r;
  assign done_out         = done_r;
  assign refused_out      = refused_r;
  assign offset_out       = offset_r;
  assign seg_out          = seg_r;
  assign phys_addr_out    = phys_r;
  assign io_cycle_out     = io_r;
  assign port_out         = port_r;
  assign src_ptr_out      = src_ptr_r;
  assign dst_ptr_out      = dst_ptr_r;
  assign dst_phys_out     = dst_phys_r;
  assign is_move_out      = is_move_r;
  assign is_transfer_out  = is_xfer_r;
  assign inc_reg_out      = inc_reg_r;
  assign inc_mem_out      = inc_mem_r;
  assign instr_len_out    = len_r;
  assign word_op_out      = word_r;
  assign mem_in_place_out = in_place_r;

  // Checks of offsets, segments and timing.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  a_direct_offset: assert property (take && mode_in == MODE_DIRECT && !override_in |->
    ##7 done_r && offset_r == $past(disp_in, 7))
    else $error("Direct offset or timing wrong.");
  a_reg_ind_base: assert property (take && mode_in == MODE_REG_IND && !override_in
    && !use_index_in && !base_sel_in |-> ##6 done_r && offset_r == $past(general_base_reg_in, 6))
    else $error("Register indirect offset wrong.");
  a_jump_target: assert property (take && mode_in == MODE_JUMP_IND |->
    ##2 done_r && offset_r == $past(jump_reg_in, 2) && seg_r == SEG_CODE)
    else $error("Jump target offset wrong.");
  a_based_stack: assert property (take && mode_in == MODE_BASED && base_sel_in
    && !override_in |-> ##10 done_r && offset_r == 16'($past(disp_in, 10) + $past(stack_base_pointer_in, 10)))
    else $error("Based offset wrong.");
  a_stack_segment: assert property (take && mode_in == MODE_BASED_INDEXED && base_sel_in
    && !override_in |-> ##[8:13] done_r && seg_r == SEG_STACK)
    else $error("Stack segment not selected.");
  a_indexed_dest: assert property (take && mode_in == MODE_INDEXED && index_sel_in
    && !override_in |-> ##10 done_r && offset_r == 16'($past(disp_in, 10) + $past(destination_index_reg_in, 10)))
    else $error("Indexed offset wrong.");
  a_full_sum_wrap: assert property (take && mode_in == MODE_BASED_INDEXED && disp_en_in
    && !base_sel_in && !index_sel_in && !override_in |-> ##12 done_r && offset_r ==
    16'($past(disp_in, 12) + $past(general_base_reg_in, 12) + $past(source_index_reg_in, 12)))
    else $error("Based indexed offset wrong.");
  a_string_load: assert property (take && mode_in == MODE_STRING |=>
    src_ptr_r == $past(source_index_reg_in) && dst_ptr_r == $past(destination_index_reg_in))
    else $error("String pointers not loaded.");
  a_string_step: assert property (step_in && !take && word_in && !dir_down_in |=>
    src_ptr_r == 16'($past(src_ptr_r) + 16'h0002) && dst_ptr_r == 16'($past(dst_ptr_r) + 16'h0002))
    else $error("String pointers not stepped.");
  a_port_direct: assert property (take && mode_in == MODE_PORT_DIRECT |->
    ##2 done_r && io_cycle_out && port_r == {8'h00, $past(port_imm_in, 2)})
    else $error("Direct port number wrong.");
  a_port_indirect: assert property (take && mode_in == MODE_PORT_INDIRECT |->
    ##2 done_r && io_cycle_out && port_r == $past(port_number_reg_in, 2))
    else $error("Indirect port number wrong.");
  a_imm_dest_refused: assert property (start_in && !busy_r && dest_imm_in |=>
    refused_r && !busy_r)
    else $error("Immediate destination accepted.");
  a_override_time: assert property (take && mode_in == MODE_DIRECT && override_in |->
    ##9 done_r && seg_r == $past(override_seg_in, 9))
    else $error("Override time or segment wrong.");
  a_inc_register: assert property (opcode_in inside {[8'h40:8'h47]} |=>
    inc_reg_r && len_r == 3'h1)
    else $error("Register increment not recognized.");

  c_based_indexed: cover property (take && mode_in == MODE_BASED_INDEXED ##[7:14] done_r);
  c_string_steps: cover property (take && mode_in == MODE_STRING ##1 step_in [*3]);
  c_port_cycle: cover property (done_r && io_r);
  c_refused: cover property (refused_r);

endmodule
`default_nettype wire

// *** core/opcode_classifier.sv ***
// Combinational classifier of first opcode byte and operand byte.
`timescale 1ns/1ps
`default_nettype none
`include "ea_consts.svh"
module opcode_classifier (
  // Instruction bytes.
  input  wire logic [7:0] opcode_in,
  input  wire logic [7:0] modrm_in,
  // Classification.
  output logic            is_move_out,
  output logic            is_transfer_out,
  output logic            inc_reg_out,
  output logic            inc_mem_out,
  output logic [2:0]      instr_len_out,
  output logic            word_op_out,
  output logic            mem_in_place_out
);

  logic mem_form;

  // Operand byte selects memory when its mode field is not register.
  assign mem_form = (modrm_in[7:6] != `MODRM_MOD_MEM);

  // Move encodings: register, memory, immediate, segment and accumulator forms.
  assign is_move_out = opcode_in inside {[8'h88:8'h8C], 8'h8E, [8'hA0:8'hA3],
                                         [8'hB0:8'hBF], 8'hC6, 8'hC7};

  // Data transfer group: move, push, pop, exchange, translate, in, out,
  // offset and pointer loads and flag transfers.
  assign is_transfer_out = is_move_out ||
      opcode_in inside {8'h8D, 8'hC4, 8'hC5, [8'h9C:8'h9F], [8'h50:8'h5F],
                        8'h8F, 8'h06, 8'h07, 8'h0E, 8'h16, 8'h17, 8'h1E,
                        8'h1F, 8'h86, 8'h87, [8'h90:8'h97], 8'hD7,
                        [8'hE4:8'hE7], [8'hEC:8'hEF]};

  // One-byte register increments, one per 16-bit register.
  assign inc_reg_out = opcode_in inside {[8'h40:8'h47]};

  // Memory increments carry the operand address in the instruction.
  assign inc_mem_out = opcode_in inside {8'hFE, 8'hFF} &&
                       (modrm_in[5:3] == 3'h0) && mem_form;

  // Length: one byte for register forms, two plus displacement for memory.
  always_comb begin
    instr_len_out = 3'h0;
    if (inc_reg_out) begin
      instr_len_out = 3'h1;
    end else if (inc_mem_out) begin
      unique case (modrm_in[7:6])
        2'h1:    instr_len_out = 3'h3;
        2'h2:    instr_len_out = 3'h4;
        default: instr_len_out = (modrm_in[2:0] == 3'h6) ? 3'h4 : 3'h2;
      endcase
    end
  end

  // Width bit sits in bit 3 for immediate-to-register moves, else bit 0.
  assign word_op_out = (opcode_in[7:4] == 4'hB) ? opcode_in[3] : opcode_in[0];

  // Arithmetic, logic, compare, shift and increment on memory operands.
  assign mem_in_place_out = mem_form &&
      ((opcode_in[7:6] == 2'h0 && opcode_in[2] == 1'b0) ||
       opcode_in inside {[8'h80:8'h83], [8'hD0:8'hD3], 8'hFE, 8'hFF});

endmodule
`default_nettype wire

// *** tb/mem_port_model.sv ***
// Model of the memory and port space that receives each completed access.
`timescale 1ns/1ps
`default_nettype none
module mem_port_model (
  // Bus side.
  input  wire logic        clk_in,
  input  wire logic        done_in,
  input  wire logic        io_in,
  input  wire logic [19:0] addr_in,
  input  wire logic [15:0] port_in,
  // Last access seen.
  output logic [19:0]      last_out
);
  // Captures the memory address or port number of each completed access.
  always_ff @(posedge clk_in) begin
    if (done_in) begin
      last_out <= io_in ? {4'h0, port_in} : addr_in;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_effective_address_gen.sv ***
// Self-checking bench of the operand offset generator.
`timescale 1ns/1ps
`default_nettype none
module test_effective_address_gen;
  import ea_pkg::*;
  logic clk_sys_in = 0, nrst_in = 0, start_in = 0, base_sel_in = 0, index_sel_in = 0, use_index_in = 0;
  logic disp_en_in = 0, override_in = 0, dest_imm_in = 0, step_in = 0, dir_down_in = 0, word_in = 0;
  mode_type mode_in = MODE_DIRECT;
  seg_type override_seg_in = SEG_EXTRA, seg_out;
  logic [15:0] disp_in = 16'h0020, general_base_reg_in = 16'h1234, stack_base_pointer_in = 16'hFFF0;
  logic [15:0] source_index_reg_in = 16'h0010, destination_index_reg_in = 16'h0020;
  logic [15:0] port_number_reg_in = 16'hBEEF, jump_reg_in = 16'h5555;
  logic [15:0] seg_extra_in = 16'h1000, seg_code_in = 16'h2000, seg_stack_in = 16'h3000, seg_data_in = 16'h4000;
  logic [7:0] port_imm_in = 8'hA5, opcode_in = 8'h90, modrm_in = 8'h00;
  logic busy_out, done_out, refused_out, io_cycle_out, is_move_out, is_transfer_out, inc_reg_out;
  logic inc_mem_out, word_op_out, mem_in_place_out;
  logic [15:0] offset_out, port_out, src_ptr_out, dst_ptr_out;
  logic [19:0] phys_addr_out, dst_phys_out, last_out;
  logic [2:0] instr_len_out;
  int fails = 0, checks = 0;
  effective_address_gen DUT (.*);
  mem_port_model partner (.clk_in(clk_sys_in), .done_in(done_out), .io_in(io_cycle_out),
                          .addr_in(phys_addr_out), .port_in(port_out), .last_out(last_out));
  // Clock of 10 ns period.
  always #5 clk_sys_in = ~clk_sys_in;
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issues one request, waits for completion, judges latency and results.
  task automatic op(mode_type m, logic b, logic i, logic u, logic d, logic o, logic [15:0] eo,
                    seg_type es, int el);
    logic [15:0] sb;
    int n;
    mode_in = m; base_sel_in = b; index_sel_in = i; use_index_in = u; disp_en_in = d; override_in = o;
    start_in = 1;
    @(posedge clk_sys_in) #1 start_in = 0;
    n = 0;
    while (done_out !== 1'b1 && n < 40) begin
      @(posedge clk_sys_in) #1 n++;
    end
    if (n >= 40) begin
      fails++;
      results();
    end
    chk("latency", el, n);
    sb = es == SEG_EXTRA ? seg_extra_in : es == SEG_CODE ? seg_code_in : es == SEG_STACK ? seg_stack_in : seg_data_in;
    if (m == MODE_PORT_DIRECT || m == MODE_PORT_INDIRECT) begin
      chk("port", eo, port_out);
    end else begin
      chk("offset", eo, offset_out);
      chk("seg", es, seg_out);
      chk("phys", {sb, 4'h0} + eo, phys_addr_out);
    end
    @(posedge clk_sys_in) #1 chk("model", io_cycle_out ? eo : {sb, 4'h0} + eo, last_out);
    $display("test mode %0d done", m);
  endtask
  task automatic string_walk();
    mode_in = MODE_STRING; override_in = 0; start_in = 1;
    @(posedge clk_sys_in) #1 start_in = 0;
    @(posedge clk_sys_in) #1 step_in = 1; word_in = 1;
    chk("src", 16'h0010, src_ptr_out);
    chk("dst", 16'h0020, dst_ptr_out);
    @(posedge clk_sys_in) #1 dir_down_in = 1; word_in = 0;
    chk("src", 16'h0012, src_ptr_out);
    @(posedge clk_sys_in) #1 step_in = 0;
    chk("dst", 16'h0021, dst_ptr_out);
    @(posedge clk_sys_in) #1 chk("dstphys", 20'h10021, dst_phys_out);
    $display("test string done");
  endtask
  task automatic refuse_and_classify();
    dest_imm_in = 1; start_in = 1; opcode_in = 8'h40;
    @(posedge clk_sys_in) #1 start_in = 0; dest_imm_in = 0;
    chk("refused", 1, refused_out);
    chk("busy", 0, busy_out);
    chk("increg", 1, inc_reg_out);
    chk("len", 1, instr_len_out);
    opcode_in = 8'hFF; modrm_in = 8'h46;
    @(posedge clk_sys_in) #1 chk("incmem", 1, inc_mem_out);
    chk("memlen", 3, instr_len_out);
    chk("word", 1, word_op_out);
    chk("inplace", 1, mem_in_place_out);
    chk("notmove", 0, is_move_out);
    opcode_in = 8'h88; modrm_in = 8'hC0;
    @(posedge clk_sys_in) #1 chk("move", 1, is_move_out);
    chk("xfer", 1, is_transfer_out);
    chk("regform", 0, mem_in_place_out);
    $display("test refuse done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_in);
    #1 nrst_in = 1;
    op(MODE_DIRECT, 0, 0, 0, 0, 0, 16'h0020, SEG_DATA, 6);
    op(MODE_REG_IND, 0, 0, 1, 0, 0, 16'h0010, SEG_DATA, 5);
    op(MODE_BASED, 1, 0, 0, 0, 0, 16'h0010, SEG_STACK, 9);
    op(MODE_INDEXED, 0, 1, 0, 0, 0, 16'h0040, SEG_DATA, 9);
    op(MODE_BASED_INDEXED, 1, 1, 0, 1, 0, 16'h0030, SEG_STACK, 11);
    op(MODE_BASED_INDEXED, 0, 0, 0, 0, 0, 16'h1244, SEG_DATA, 7);
    op(MODE_DIRECT, 0, 0, 0, 0, 1, 16'h0020, SEG_EXTRA, 8);
    op(MODE_JUMP_IND, 0, 0, 0, 0, 0, 16'h5555, SEG_CODE, 1);
    op(MODE_PORT_DIRECT, 0, 0, 0, 0, 0, 16'h00A5, SEG_DATA, 1);
    op(MODE_PORT_INDIRECT, 0, 0, 0, 0, 0, 16'hBEEF, SEG_DATA, 1);
    string_walk();
    refuse_and_classify();
    results();
  end
endmodule
`default_nettype wire
